// [dv/tb_top.sv]
`timescale 1ns/1ps
// device and far end joined on one line; bench drives both user sides
module tb_top;
   localparam int BD = 4; // short bit time keeps a frame at 44 cycles
   logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic        send_valid, send_is_addr, send_ready, recv_valid;
   logic [7:0]  awaddr, araddr, send_byte;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [8:0]  recv_word;
   int          n_mismatch, tests_run, cyc;

   umaf_if umaf_if_i ();
   umaf_device #(.BAUD_DIV(BD)) umaf_device_i (.mclk(mclk), .rst(rst),
      .link(umaf_if_i.device), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq));
   umaf_far #(.BAUD_DIV(BD)) umaf_far_i (.mclk(mclk), .rst(rst), .link(umaf_if_i.far),
      .send_valid(send_valid), .send_is_addr(send_is_addr), .send_byte(send_byte),
      .send_ready(send_ready), .recv_valid(recv_valid), .recv_word(recv_word));
   umaf_chk umaf_chk_i (.mclk(mclk), .rst(rst), .dev_tx(umaf_if_i.dev_tx),
      .host_tx(umaf_if_i.host_tx), .line(umaf_if_i.line), .irq(irq),
      .s_axi_awready(awready), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .recv_valid(recv_valid));

   // clock, and a cycle ceiling well above the several hundred cycles needed
   always #4 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         n_mismatch++;
         $display("[ERR] timeout expected finish seen hang");
         test_done();
      end
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write; address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            chk("bresp", {30'h0, er}, {30'h0, bresp});
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = 2'b00);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge mclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            chk(what, exp, rdata);
            chk("rresp", {30'h0, er}, {30'h0, rresp});
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // far end sends one 9-bit frame; the wait covers a whole frame
   task automatic send(input logic is_addr, input logic [7:0] b);
      @(posedge mclk);
      send_is_addr <= is_addr;
      send_byte <= b;
      send_valid <= 1'b1;
      do
         @(posedge mclk);
      while (!send_ready);
      send_valid <= 1'b0;
      repeat (12 * BD) @(posedge mclk);
   endtask

   task automatic t_regs;
      rd("ctrl", umaf_pkg::OFF_CTRL, 32'h0);
      rd("status", umaf_pkg::OFF_STATUS, 32'h0);
      wr(umaf_pkg::OFF_CTRL, 32'he8);
      rd("ctrl rw", umaf_pkg::OFF_CTRL, 32'ha8);
      rd("unmapped", 8'h10, 32'h0, umaf_pkg::RESP_SLVERR);
      wr(8'h14, 32'h1, umaf_pkg::RESP_SLVERR);
      wr(8'h02, 32'h0, umaf_pkg::RESP_SLVERR);
      $display("t_regs done");
   endtask

   // nine-bit filter: data ignored, address taken, overrun dropped
   task automatic t_filter9;
      wr(umaf_pkg::OFF_MASK, 32'h1);
      wr(umaf_pkg::OFF_CTRL, 32'hb0);
      send(1'b0, 8'h5a);
      rd("ctrl data", umaf_pkg::OFF_CTRL, 32'hb0);
      rd("drop", umaf_pkg::OFF_STATUS, 32'h4);
      chk("irq", 32'h0, {31'h0, irq});
      send(1'b1, 8'h3c);
      rd("ctrl addr", umaf_pkg::OFF_CTRL, 32'hb5);
      rd("rx addr", umaf_pkg::OFF_DATA, 32'h3c);
      chk("irq", 32'h1, {31'h0, irq});
      send(1'b1, 8'h77);
      rd("overrun", umaf_pkg::OFF_DATA, 32'h3c);
      wr(umaf_pkg::OFF_STATUS, 32'h7);
      chk("irq clr", 32'h0, {31'h0, irq});
      wr(umaf_pkg::OFF_CTRL, 32'h90);
      send(1'b0, 8'h11);
      rd("ctrl open", umaf_pkg::OFF_CTRL, 32'h91);
      rd("rx data", umaf_pkg::OFF_DATA, 32'h11);
      // message over: filter armed again, data ignored, next address taken
      wr(umaf_pkg::OFF_CTRL, 32'hb0);
      send(1'b0, 8'h2d);
      rd("ctrl rearm", umaf_pkg::OFF_CTRL, 32'hb0);
      send(1'b1, 8'h3d);
      rd("rx addr2", umaf_pkg::OFF_DATA, 32'h3d);
      $display("t_filter9 done");
   endtask

   task automatic t_rx_off;
      wr(umaf_pkg::OFF_CTRL, 32'h80);
      send(1'b1, 8'h22);
      rd("ctrl off", umaf_pkg::OFF_CTRL, 32'h80);
      rd("rx off", umaf_pkg::OFF_DATA, 32'h3d);
      $display("t_rx_off done");
   endtask

   // eight-bit: device sees the far ninth bit as its stop bit
   task automatic t_8bit;
      wr(umaf_pkg::OFF_CTRL, 32'h30);
      send(1'b1, 8'h44);
      rd("ctrl stop1", umaf_pkg::OFF_CTRL, 32'h35);
      rd("rx stop1", umaf_pkg::OFF_DATA, 32'h44);
      wr(umaf_pkg::OFF_CTRL, 32'h30);
      send(1'b0, 8'h66);
      rd("ctrl stop0", umaf_pkg::OFF_CTRL, 32'h30);
      wr(umaf_pkg::OFF_CTRL, 32'h10);
      send(1'b0, 8'h66);
      rd("ctrl nofilt", umaf_pkg::OFF_CTRL, 32'h11);
      rd("rx nofilt", umaf_pkg::OFF_DATA, 32'h66);
      $display("t_8bit done");
   endtask

   // device sends with ninth bit one then zero; far end reports the word
   task automatic t_tx;
      int k;
      for (int i = 0; i < 2; i++)
      begin
         wr(umaf_pkg::OFF_STATUS, 32'h7);
         wr(umaf_pkg::OFF_MASK, 32'h2);
         wr(umaf_pkg::OFF_CTRL, (i == 0) ? 32'h88 : 32'h80);
         wr(umaf_pkg::OFF_DATA, (i == 0) ? 32'h5a : 32'ha5);
         k = 0;
         while (!recv_valid && k < 20 * BD)
         begin
            @(posedge mclk);
            k++;
         end
         chk("recv", (i == 0) ? 32'h15a : 32'h0a5, {23'h0, recv_word});
         rd("tx flag", umaf_pkg::OFF_CTRL, (i == 0) ? 32'h8a : 32'h82);
         chk("irq tx", 32'h1, {31'h0, irq});
      end
      $display("t_tx done");
   endtask

   // mid-run reset; flags, mask and irq left set by the tx test must clear
   task automatic t_reset;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd("ctrl rst", umaf_pkg::OFF_CTRL, 32'h0);
      rd("mask rst", umaf_pkg::OFF_MASK, 32'h0);
      chk("irq rst", 32'h0, {31'h0, irq});
      $display("t_reset done");
   endtask

   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, send_valid, send_is_addr} = 7'h0;
      {awaddr, araddr, send_byte} = 24'h0;
      wdata = 32'h0;
      n_mismatch = 0;
      tests_run = 0;
      cyc = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_filter9();
      t_rx_off();
      t_8bit();
      t_tx();
      t_reset();
      test_done();
   end
endmodule // tb_top

// [dv/umaf_chk.sv]
`timescale 1ns/1ps
// watches the shared line, the far receiver and the bus answers
module umaf_chk (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // link
   input wire logic        dev_tx,
   input wire logic        host_tx,
   input wire logic        line,
   // device bus and interrupt
   input wire logic        irq,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // far receiver
   input wire logic        recv_valid
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // bench runs four cycles a bit, so any level lasts at least four
   reset_idle_a: assert property ($fell(rst) |-> dev_tx && host_tx && line && !irq)
      else $error("line or irq not idle after reset");
   tx_low_len_a: assert property ($fell(dev_tx) |-> !dev_tx [*4])
      else $error("device low bit shorter than a bit time");
   tx_high_len_a: assert property ($rose(dev_tx) |-> dev_tx [*4])
      else $error("device high bit shorter than a bit time");
   far_low_len_a: assert property ($fell(host_tx) |-> !host_tx [*4])
      else $error("far end low bit shorter than a bit time");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   // a taken read is answered on the very next edge, never later
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not one cycle after address");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while answer pending");
   recv_pulse_a: assert property (recv_valid |=> !recv_valid)
      else $error("far receive strobe longer than one cycle");
endmodule // umaf_chk

// [src/umaf_device.sv]
`timescale 1ns/1ps
module umaf_device #(
   parameter int BAUD_DIV = umaf_pkg::DEF_BAUD_DIV
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // link
   umaf_if.device           link,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // interrupt
   output logic             irq
);
   logic [7:0]  ctrl_reg;
   logic [7:0]  rxbuf_reg;
   logic [7:0]  txbuf_reg;
   logic        tx_go_reg;
   logic [umaf_pkg::EV_WIDTH-1:0] stat_reg;
   logic [umaf_pkg::EV_WIDTH-1:0] mask_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic        tx_busy;
   logic        tx_done;
   logic        rx_frame;
   logic [8:0]  rx_word;
   logic        rx_stop;
   logic        pass;
   logic        accept;
   logic        nine;
   logic        filt;
   logic [7:0]  rd_val;
   logic        rd_ok;

   assign nine = ctrl_reg[umaf_pkg::BIT_FORMAT];
   assign filt = ctrl_reg[umaf_pkg::BIT_FILTER];

   umaf_serial #(.BAUD_DIV(BAUD_DIV)) u_ser (
      .mclk      (mclk),
      .rst       (rst),
      .nine_bit  (nine),
      .rx_enable (ctrl_reg[umaf_pkg::BIT_RX_EN]),
      .tx_start  (tx_go_reg),
      .tx_word   ({ctrl_reg[umaf_pkg::BIT_TX9], txbuf_reg}),
      .tx_busy   (tx_busy),
      .tx_done   (tx_done),
      .txd       (link.dev_tx),
      .rxd       (link.line),
      .rx_frame  (rx_frame),
      .rx_word   (rx_word),
      .rx_stop   (rx_stop)
   );

   // filter condition: ninth bit in 9-bit mode, stop bit in 8-bit
   always_comb
   begin
      if (!filt)
         pass = 1'b1;
      else if (nine)
         pass = rx_word[8];
      else
         pass = rx_stop;
   end
   // a failing frame is just dropped; engine already hunts again
   assign accept = rx_frame && pass && !ctrl_reg[umaf_pkg::BIT_RX_DONE];

   // axi write capture, address and data in either order
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_addr_reg  <= '0;
         w_data_reg   <= '0;
         w_strb_reg   <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= umaf_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg > umaf_pkg::OFF_MASK || aw_addr_reg[1:0] != 2'b00)
                            ? umaf_pkg::RESP_SLVERR : umaf_pkg::RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control register; hardware sets of the flags win over writes
   always_ff @(posedge mclk)
   begin
      tx_go_reg <= 1'b0;
      if (rst)
      begin
         ctrl_reg  <= umaf_pkg::CTRL_RESET;
         txbuf_reg <= '0;
         rxbuf_reg <= '0;
      end
      else
      begin
         if (wr_fire && w_strb_reg[0] && aw_addr_reg == umaf_pkg::OFF_CTRL)
            ctrl_reg <= w_data_reg[7:0] & umaf_pkg::CTRL_WMASK;
         if (wr_fire && w_strb_reg[0] && aw_addr_reg == umaf_pkg::OFF_DATA && !tx_busy)
         begin
            txbuf_reg <= w_data_reg[7:0];
            tx_go_reg <= 1'b1;
         end
         if (tx_done)
            ctrl_reg[umaf_pkg::BIT_TX_DONE] <= 1'b1;
         if (accept)
         begin
            rxbuf_reg                       <= rx_word[7:0];
            ctrl_reg[umaf_pkg::BIT_RX9]     <= nine ? rx_word[8] : rx_stop;
            ctrl_reg[umaf_pkg::BIT_RX_DONE] <= 1'b1;
         end
      end
   end

   // sticky events, write one to clear, set wins
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stat_reg <= '0;
         mask_reg <= '0;
      end
      else
      begin
         if (wr_fire && w_strb_reg[0] && aw_addr_reg == umaf_pkg::OFF_MASK)
            mask_reg <= w_data_reg[umaf_pkg::EV_WIDTH-1:0];
         stat_reg <= (stat_reg & ~((wr_fire && w_strb_reg[0] && aw_addr_reg == umaf_pkg::OFF_STATUS)
                     ? w_data_reg[umaf_pkg::EV_WIDTH-1:0] : '0))
                     | {rx_frame && !accept, tx_done, accept};
      end
   end
   assign irq = |(stat_reg & mask_reg);

   // read decode
   always_comb
   begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         umaf_pkg::OFF_CTRL:   rd_val = ctrl_reg;
         umaf_pkg::OFF_DATA:   rd_val = rxbuf_reg;
         umaf_pkg::OFF_STATUS: rd_val = {5'h00, stat_reg};
         umaf_pkg::OFF_MASK:   rd_val = {5'h00, mask_reg};
         default:
         begin
            rd_val = 8'h00;
            rd_ok  = 1'b0;
         end
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= umaf_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_val};
         s_axi_rresp  <= rd_ok ? umaf_pkg::RESP_OKAY : umaf_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // umaf_device

// [src/umaf_far.sv]
`timescale 1ns/1ps
// far-end node: master sending address then data, and plain receiver
module umaf_far #(
   parameter int BAUD_DIV = umaf_pkg::DEF_BAUD_DIV
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // link
   umaf_if.far             link,
   // user side
   input  wire logic       send_valid,
   input  wire logic       send_is_addr,
   input  wire logic [7:0] send_byte,
   output logic            send_ready,
   output logic            recv_valid,
   output logic [8:0]      recv_word
);
   logic busy;
   logic frame;
   logic [8:0] word;

   // ninth bit one for addresses, zero for data
   umaf_serial #(.BAUD_DIV(BAUD_DIV)) u_ser (
      .mclk      (mclk),
      .rst       (rst),
      .nine_bit  (1'b1),
      .rx_enable (1'b1),
      .tx_start  (send_valid),
      .tx_word   ({send_is_addr, send_byte}),
      .tx_busy   (busy),
      .tx_done   (),
      .txd       (link.host_tx),
      .rxd       (link.line),
      .rx_frame  (frame),
      .rx_word   (word),
      .rx_stop   ()
   );
   // order of address before data is the user's duty
   assign send_ready = !busy;

   // master listens to all traffic
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         recv_valid <= 1'b0;
         recv_word  <= '0;
      end
      else
      begin
         recv_valid <= frame;
         if (frame)
            recv_word <= word;
      end
   end
endmodule // umaf_far

// [src/umaf_if.sv]
`timescale 1ns/1ps
// shared multidrop line; both ends drive open-drain style
interface umaf_if;
   logic dev_tx;  // device's serial output
   logic host_tx; // far end's serial output
   logic line;    // wired-and of both
   assign line = dev_tx & host_tx;
   modport device (output dev_tx, input line);
   modport far (output host_tx, input line);
endinterface

// [src/umaf_pkg.sv]
package umaf_pkg;
   // serial_port_control bit positions
   localparam int BIT_FORMAT   = 7;
   localparam int BIT_FILTER   = 5;
   localparam int BIT_RX_EN    = 4;
   localparam int BIT_TX9      = 3;
   localparam int BIT_RX9      = 2;
   localparam int BIT_TX_DONE  = 1;
   localparam int BIT_RX_DONE  = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hbf; // bit 6 unused, reads zero

   // register bank word offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_DATA   = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK   = 8'h0c;

   // interrupt status bits
   localparam int EV_RX     = 0;
   localparam int EV_TX     = 1;
   localparam int EV_DROP   = 2;
   localparam int EV_WIDTH  = 3;

   // serial timing
   localparam int DEF_BAUD_DIV = 16; // mclk cycles per bit
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [3:0] DATA_BITS   = 4'h8;
endpackage

// [src/umaf_serial.sv]
`timescale 1ns/1ps
// one-frame serial engine: tx shifter and rx sampler, 8 or 9 data bits
module umaf_serial #(
   parameter int BAUD_DIV = umaf_pkg::DEF_BAUD_DIV
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // configuration
   input  wire logic       nine_bit,
   input  wire logic       rx_enable,
   // transmit
   input  wire logic       tx_start,
   input  wire logic [8:0] tx_word,
   output logic            tx_busy,
   output logic            tx_done,
   output logic            txd,
   // receive
   input  wire logic       rxd,
   output logic            rx_frame,
   output logic [8:0]      rx_word,
   output logic            rx_stop
);
   localparam int CW = $clog2(BAUD_DIV + 1);
   localparam logic [CW-1:0] DIV_LAST = CW'(BAUD_DIV - 1);
   localparam logic [CW-1:0] DIV_HALF = CW'(BAUD_DIV / 2);

   logic [CW-1:0] tx_cnt_reg;
   logic [3:0]    tx_bit_reg;
   logic [10:0]   tx_sh_reg;
   logic [CW-1:0] rx_cnt_reg;
   logic [3:0]    rx_bit_reg;
   logic          rx_act_reg;
   logic [9:0]    rx_sh_reg;
   logic [3:0]    frame_bits;

   // data bits plus stop after start
   assign frame_bits = nine_bit ? umaf_pkg::DATA_BITS + 4'h2 : umaf_pkg::DATA_BITS + 4'h1;

   // transmitter; done pulses at the start of the stop bit
   always_ff @(posedge mclk)
   begin
      tx_done <= 1'b0;
      if (rst)
      begin
         tx_busy    <= 1'b0;
         txd        <= 1'b1;
         tx_cnt_reg <= '0;
         tx_bit_reg <= '0;
         tx_sh_reg  <= '1;
      end
      else if (!tx_busy)
      begin
         if (tx_start)
         begin
            tx_busy    <= 1'b1;
            txd        <= 1'b0; // start bit
            tx_sh_reg  <= nine_bit ? {2'b11, tx_word} : {3'b111, tx_word[7:0]};
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
         end
      end
      else if (tx_cnt_reg == DIV_LAST)
      begin
         tx_cnt_reg <= '0;
         if (tx_bit_reg == frame_bits)
         begin
            tx_busy <= 1'b0;
            txd     <= 1'b1;
         end
         else
         begin
            txd        <= tx_sh_reg[0];
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_done    <= (tx_bit_reg + 4'h1) == frame_bits;
         end
      end
      else
         tx_cnt_reg <= tx_cnt_reg + CW'(1);
   end

   // receiver; sample mid-bit, frame pulse after stop bit sample
   always_ff @(posedge mclk)
   begin
      rx_frame <= 1'b0;
      if (rst || !rx_enable)
      begin
         rx_act_reg <= 1'b0;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_sh_reg  <= '0;
         rx_word    <= '0;
         rx_stop    <= 1'b0;
      end
      else if (!rx_act_reg)
      begin
         if (!rxd)
         begin
            rx_act_reg <= 1'b1;
            rx_cnt_reg <= DIV_HALF; // land on bit centres
            rx_bit_reg <= '0;
         end
      end
      else if (rx_cnt_reg == DIV_LAST)
      begin
         rx_cnt_reg <= '0;
         if (rx_bit_reg == 4'h0 && rxd)
            rx_act_reg <= 1'b0; // false start
         else if (rx_bit_reg == frame_bits)
         begin
            rx_act_reg <= 1'b0; // back to start hunt either way
            rx_frame   <= 1'b1;
            rx_stop    <= rxd;
            rx_word    <= nine_bit ? rx_sh_reg[9:1] : {1'b0, rx_sh_reg[9:2]};
         end
         else
         begin
            rx_sh_reg  <= {rxd, rx_sh_reg[9:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
         end
      end
      else
         rx_cnt_reg <= rx_cnt_reg + CW'(1);
   end
endmodule // umaf_serial
